// ==== logic/svrw_pkg.sv ====
`default_nettype none
package svrw_pkg;
	// ----------------------------------------------------------------
	// clock and internal time base
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_MS = 1000000 / TICK_NS;

	// ----------------------------------------------------------------
	// supervisor times, in their own units, and their tick counts
	// ----------------------------------------------------------------
	localparam int unsigned RESET_TIMEOUT_MS = 140;
	localparam int unsigned WDOG_TIMEOUT_MS = 1600;
	localparam int unsigned WDOG_STARTUP_S = 54;
	localparam logic [31:0] RESET_TIMEOUT_TICKS = 32'(RESET_TIMEOUT_MS * TICKS_PER_MS);
	localparam logic [31:0] WDOG_TIMEOUT_TICKS = 32'(WDOG_TIMEOUT_MS * TICKS_PER_MS);
	localparam logic [31:0] WDOG_STARTUP_TICKS = 32'(WDOG_STARTUP_S * 1000 * TICKS_PER_MS);

	// ----------------------------------------------------------------
	// register map (byte offsets) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_EXT_TIMEOUT = 8'h08;
	localparam logic [7:0] REG_LIVE = 8'h0c;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [31:0] EXT_TIMEOUT_RST = RESET_TIMEOUT_TICKS;

	// status / mask bit positions
	localparam int unsigned EV_RAIL_DROP = 0;
	localparam int unsigned EV_MANUAL = 1;
	localparam int unsigned EV_WDOG = 2;
	localparam int unsigned EV_RELEASE = 3;
	localparam int unsigned EV_COUNT = 4;

	// live register bit positions
	localparam int unsigned LIVE_RESET = 6;
	localparam int unsigned LIVE_WD_EN = 7;
	localparam int unsigned LIVE_WD_STATE = 8;
	localparam int unsigned LIVE_MARGIN = 10;
	localparam int unsigned LIVE_SELECT = 11;

	// register select codes
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_MASK = 3'h2;
	localparam logic [2:0] SEL_EXT = 3'h3;
	localparam logic [2:0] SEL_LIVE = 3'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WD_OFF,
		WD_STARTUP,
		WD_RUN
	} svrw_wd_state_t;
endpackage
`default_nettype wire

// ==== logic/svrw_pin_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; output follows once stages two and three agree
module svrw_pin_filter #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			pin_out <= RST_VAL;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (s2_q[i] == s3_q[i])
					pin_out[i] <= s3_q[i];
			end
		end
	end
endmodule // svrw_pin_filter
`default_nettype wire

// ==== logic/svrw_supervisor.sv ====
// Summary of operation
// - a watchdog input held at one level past the watchdog timeout asserts system reset and clears the timer.
// - the watchdog timer restarts from zero while system reset is asserted and on every edge of the watchdog input.
// - after a reset the watchdog allows a 54 s startup period for the first input transition before it may reset.
// - a floating watchdog input disables the watchdog; a host wanting it off leaves the input undriven.
// - each channel fault output is low while its rail is below threshold and released once it is above again.
// - manual reset low asserts system reset, which stays asserted a full reset timeout after release.
// - timeout select high picks the internal 140 ms timeout, otherwise the timeout held in the external-timeout register applies.
// - margin low forces every fault output and the system reset to the released high state.
// - any rail below threshold asserts system reset, held a reset timeout after all rails and manual reset recover.
`timescale 1ns/1ps
`default_nettype none
module svrw_supervisor #(
	parameter int unsigned RAILS = 6,
	parameter int unsigned TICK_DIV = svrw_pkg::TICK_CYCLES,
	parameter logic [31:0] RESET_TICKS = svrw_pkg::RESET_TIMEOUT_TICKS,
	parameter logic [31:0] WDOG_TICKS = svrw_pkg::WDOG_TIMEOUT_TICKS,
	parameter logic [31:0] STARTUP_TICKS = svrw_pkg::WDOG_STARTUP_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [RAILS-1:0] monitored_rail,
	input wire logic manual_reset_request_n,
	input wire logic timeout_select_input,
	input wire logic margin_n,
	input wire logic watchdog_kick_input,
	input wire logic watchdog_float_detect,
	output logic [RAILS-1:0] channel_fault_n,
	output logic [RAILS-1:0] channel_fault_oe,
	output logic system_reset_n,
	output logic system_reset_oe,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [RAILS-1:0] rail_ok_s;
	logic [4:0] ctl_s;
	logic mr_s;
	logic select_s;
	logic margin_s;
	logic wdi_s;
	logic float_s;

	svrw_pin_filter #(.WIDTH(RAILS), .RST_VAL('0)) u_rail_filter (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(monitored_rail),
		.pin_out(rail_ok_s)
	);

	svrw_pin_filter #(.WIDTH(5), .RST_VAL(5'h1d)) u_ctl_filter (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in({manual_reset_request_n, timeout_select_input, margin_n, watchdog_kick_input,
			watchdog_float_detect}),
		.pin_out(ctl_s)
	);

	assign mr_s = ctl_s[4];
	assign select_s = ctl_s[3];
	assign margin_s = ctl_s[2];
	assign wdi_s = ctl_s[1];
	assign float_s = ctl_s[0];

	// ----------------------------------------------------------------
	// internal time base
	// ----------------------------------------------------------------
	logic [15:0] tick_cnt_q;
	logic tick_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (tick_cnt_q >= 16'(TICK_DIV - 1))
		begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// reset generator
	// ----------------------------------------------------------------
	logic all_ok;
	logic wd_expire;
	logic rst_active_q;
	logic rst_active_d;
	logic [31:0] hold_cnt_q;
	logic [31:0] hold_cnt_d;
	logic [31:0] ext_timeout_q;
	logic [31:0] timeout_ticks;

	assign all_ok = &rail_ok_s;
	assign timeout_ticks = select_s ? RESET_TICKS : ext_timeout_q;

	always_comb
	begin
		rst_active_d = rst_active_q;
		hold_cnt_d = hold_cnt_q;
		if (!all_ok || !mr_s || wd_expire)
		begin
			rst_active_d = 1'b1;
			hold_cnt_d = 32'h0000_0000;
		end
		else if (rst_active_q && tick_q)
		begin
			if (hold_cnt_q + 32'h0000_0001 >= timeout_ticks)
				rst_active_d = 1'b0;
			else
				hold_cnt_d = hold_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_active_q <= 1'b1;
			hold_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			rst_active_q <= rst_active_d;
			hold_cnt_q <= hold_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	svrw_pkg::svrw_wd_state_t wd_state_q;
	logic [31:0] wd_cnt_q;
	logic wdi_prev_q;
	logic wdi_edge;
	logic wd_armed;
	logic [31:0] wd_limit;

	assign wdi_edge = wdi_s ^ wdi_prev_q;
	assign wd_armed = (wd_state_q == svrw_pkg::WD_STARTUP) || (wd_state_q == svrw_pkg::WD_RUN);
	assign wd_limit = (wd_state_q == svrw_pkg::WD_RUN) ? WDOG_TICKS : STARTUP_TICKS;
	assign wd_expire = !float_s && !rst_active_q && wd_armed && !wdi_edge && tick_q
		&& (wd_cnt_q + 32'h0000_0001 >= wd_limit);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_state_q <= svrw_pkg::WD_OFF;
			wd_cnt_q <= 32'h0000_0000;
			wdi_prev_q <= 1'b0;
		end
		else
		begin
			wdi_prev_q <= wdi_s;
			if (float_s)
			begin
				wd_state_q <= svrw_pkg::WD_OFF;
				wd_cnt_q <= 32'h0000_0000;
			end
			else if (rst_active_q)
			begin
				wd_state_q <= svrw_pkg::WD_STARTUP;
				wd_cnt_q <= 32'h0000_0000;
			end
			else
			begin
				case (wd_state_q)
					svrw_pkg::WD_OFF:
					begin
						wd_state_q <= svrw_pkg::WD_STARTUP;
						wd_cnt_q <= 32'h0000_0000;
					end
					default:
					begin
						if (wdi_edge)
						begin
							wd_state_q <= svrw_pkg::WD_RUN;
							wd_cnt_q <= 32'h0000_0000;
						end
						else if (wd_expire)
							wd_cnt_q <= 32'h0000_0000;
						else if (tick_q)
							wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel_fault_n <= '1;
			channel_fault_oe <= '0;
			system_reset_n <= 1'b1;
			system_reset_oe <= 1'b0;
		end
		else
		begin
			channel_fault_n <= margin_s ? rail_ok_s : '1;
			channel_fault_oe <= margin_s ? ~rail_ok_s : '0;
			system_reset_n <= margin_s ? !rst_active_d : 1'b1;
			system_reset_oe <= margin_s && rst_active_d;
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	logic all_ok_prev_q;
	logic mr_prev_q;
	logic [3:0] events;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [3:0] status_clr;

	assign events = {rst_active_q && !rst_active_d, wd_expire, mr_prev_q && !mr_s, all_ok_prev_q && !all_ok};

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			all_ok_prev_q <= 1'b0;
			mr_prev_q <= 1'b1;
			status_q <= svrw_pkg::STATUS_RST;
			irq <= 1'b0;
		end
		else
		begin
			all_ok_prev_q <= all_ok;
			mr_prev_q <= mr_s;
			// a new event wins over a simultaneous clear
			status_q <= (status_q & ~status_clr) | events;
			irq <= |(((status_q & ~status_clr) | events) & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [7:0] addr);
		if (addr[7:2] == svrw_pkg::REG_STATUS[7:2])
			return svrw_pkg::SEL_STATUS;
		else if (addr[7:2] == svrw_pkg::REG_MASK[7:2])
			return svrw_pkg::SEL_MASK;
		else if (addr[7:2] == svrw_pkg::REG_EXT_TIMEOUT[7:2])
			return svrw_pkg::SEL_EXT;
		else if (addr[7:2] == svrw_pkg::REG_LIVE[7:2])
			return svrw_pkg::SEL_LIVE;
		else
			return svrw_pkg::SEL_NONE;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = data[8*b +: 8];
		end
		return res;
	endfunction

	logic [7:0] aw_addr_q;
	logic aw_full_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_full_q;
	logic do_write;
	logic [2:0] wsel;
	logic [31:0] clr_word;
	logic [31:0] mask_word;

	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wsel = reg_sel(aw_addr_q);
	assign clr_word = lane_merge(32'h0000_0000, w_data_q, w_strb_q);
	assign mask_word = lane_merge({28'h0000000, mask_q}, w_data_q, w_strb_q);
	assign status_clr = (do_write && wsel == svrw_pkg::SEL_STATUS) ? clr_word[3:0] : 4'h0;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_addr_q <= 8'h00;
			aw_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			w_full_q <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= svrw_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wsel == svrw_pkg::SEL_NONE) ? svrw_pkg::RESP_SLVERR : svrw_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_q <= svrw_pkg::MASK_RST;
			ext_timeout_q <= svrw_pkg::EXT_TIMEOUT_RST;
		end
		else if (do_write && wsel == svrw_pkg::SEL_MASK)
			mask_q <= mask_word[3:0];
		else if (do_write && wsel == svrw_pkg::SEL_EXT)
			ext_timeout_q <= lane_merge(ext_timeout_q, w_data_q, w_strb_q);
	end

	logic [31:0] live_word;
	logic [2:0] rsel;

	always_comb
	begin
		live_word = 32'h0000_0000;
		live_word[RAILS-1:0] = rail_ok_s;
		live_word[svrw_pkg::LIVE_RESET] = rst_active_q;
		live_word[svrw_pkg::LIVE_WD_EN] = !float_s;
		live_word[svrw_pkg::LIVE_WD_STATE +: 2] = wd_state_q;
		live_word[svrw_pkg::LIVE_MARGIN] = !margin_s;
		live_word[svrw_pkg::LIVE_SELECT] = select_s;
	end

	assign rsel = reg_sel(s_axi_araddr);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= svrw_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= svrw_pkg::RESP_OKAY;
			if (rsel == svrw_pkg::SEL_STATUS)
				s_axi_rdata <= {28'h0000000, status_q};
			else if (rsel == svrw_pkg::SEL_MASK)
				s_axi_rdata <= {28'h0000000, mask_q};
			else if (rsel == svrw_pkg::SEL_EXT)
				s_axi_rdata <= ext_timeout_q;
			else if (rsel == svrw_pkg::SEL_LIVE)
				s_axi_rdata <= live_word;
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= svrw_pkg::RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	wdog_expiry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wd_expire |=> rst_active_q && wd_cnt_q == 32'h0000_0000)
		else $error("watchdog expiry did not assert reset and clear the timer");

	wdog_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_active_q || (wdi_edge && wd_armed)) |=> wd_cnt_q == 32'h0000_0000)
		else $error("watchdog timer not restarted");

	startup_grace_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wd_state_q == svrw_pkg::WD_STARTUP && wd_cnt_q + 32'h0000_0001 < STARTUP_TICKS) |-> !wd_expire)
		else $error("watchdog fired inside the startup period");

	float_disable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		float_s |-> ##1 (wd_state_q == svrw_pkg::WD_OFF && !wd_expire))
		else $error("watchdog active with floating input");

	fault_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		margin_s |=> channel_fault_n == $past(rail_ok_s))
		else $error("fault outputs do not follow rails");

	manual_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(rst_active_q) |-> $past(hold_cnt_q) + 32'h0000_0001 >= $past(timeout_ticks) && $past(mr_s))
		else $error("reset released before timeout or with manual reset low");

	timeout_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		select_s |-> timeout_ticks == RESET_TICKS)
		else $error("internal timeout not selected");

	margin_force_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!margin_s |=> (&channel_fault_n) && system_reset_n && !system_reset_oe)
		else $error("margin did not release outputs");

	rail_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(margin_s && (!all_ok || !mr_s)) |=> !system_reset_n ##1 rst_active_q)
		else $error("low rail or manual reset did not assert reset");

	tick_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tick_q |=> !tick_q ##0 tick_cnt_q == 16'h0001)
		else $error("time base tick malformed");
endmodule // svrw_supervisor
`default_nettype wire

// ==== tb/svrw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// host side: kicks the watchdog, holds manual reset, may float the kick line
// ----
module svrw_host_model (
	input wire logic core_clk,
	input wire logic kick_en,
	input wire logic float_en,
	input wire logic mr_hold,
	output logic watchdog_kick_input,
	output logic watchdog_float_detect,
	output logic manual_reset_request_n
);
	logic [2:0] div_q = 3'h0;
	logic kick_q = 1'b0;
	always_ff @(posedge core_clk)
	begin
		div_q <= div_q + 3'h1;
		if (kick_en && !float_en && div_q == 3'h7)
			kick_q <= ~kick_q;
	end
	// undriven line keeps the inverse of the last driven level, no edges
	assign watchdog_kick_input = float_en ? ~kick_q : kick_q;
	assign watchdog_float_detect = float_en;
	assign manual_reset_request_n = ~mr_hold;
endmodule // svrw_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int TDIV = 2;
	localparam int RTK = 5;
	localparam int WTK = 20;
	localparam int STK = 40;
	typedef struct packed {logic [5:0] rail; logic [5:0] fault_n; logic rst_n;} svrw_row_t;
	svrw_row_t rows [7] = '{'{6'h3e, 6'h3e, 1'b0}, '{6'h3f, 6'h3f, 1'b0}, '{6'h01, 6'h01, 1'b0},
		'{6'h20, 6'h20, 1'b0}, '{6'h15, 6'h15, 1'b0}, '{6'h2a, 6'h2a, 1'b0}, '{6'h3f, 6'h3f, 1'b0}};
	logic core_clk, rst_n, manual_reset_request_n, timeout_select_input, margin_n;
	logic [5:0] monitored_rail, channel_fault_n, channel_fault_oe;
	logic watchdog_kick_input, watchdog_float_detect, system_reset_n, system_reset_oe, irq;
	logic kick_en, float_en, mr_hold;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int n_fail, comparisons, n;

	svrw_supervisor #(.TICK_DIV(TDIV), .RESET_TICKS(32'(RTK)), .WDOG_TICKS(32'(WTK)),
		.STARTUP_TICKS(32'(STK))) DUT (.core_clk(core_clk), .rst_n(rst_n), .monitored_rail(monitored_rail),
		.manual_reset_request_n(manual_reset_request_n), .timeout_select_input(timeout_select_input),
		.margin_n(margin_n), .watchdog_kick_input(watchdog_kick_input),
		.watchdog_float_detect(watchdog_float_detect), .channel_fault_n(channel_fault_n),
		.channel_fault_oe(channel_fault_oe), .system_reset_n(system_reset_n),
		.system_reset_oe(system_reset_oe), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	svrw_host_model host (.core_clk(core_clk), .kick_en(kick_en), .float_en(float_en), .mr_hold(mr_hold),
		.watchdog_kick_input(watchdog_kick_input), .watchdog_float_detect(watchdog_float_detect),
		.manual_reset_request_n(manual_reset_request_n));

	// ----
	// checks and bus tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_span(input int v, input int lo, input int hi);
		comparisons++;
		if (v < lo || v > hi)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic conclude;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_lvl(input logic lv, input int lim);
		n = 0;
		while (system_reset_n !== lv && n < lim)
		begin
			@(posedge core_clk);
			n++;
		end
		if (system_reset_n !== lv)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, system_reset_n, lv);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			k++;
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && k < 60);
		r = bresp;
		chk_span(k, 1, 59);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			k++;
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && k < 60);
		d = rdata;
		r = rresp;
		chk_span(k, 1, 59);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		conclude();
	end

	// ----
	// main sequence
	// ----
	initial
	begin
		{rst_n, margin_n, timeout_select_input, kick_en, float_en, mr_hold} = 6'b011100;
		monitored_rail = 6'h3f;
		{awaddr, araddr, wdata, wstrb} = 52'h000000000000f;
		{awvalid, wvalid, arvalid, bready, rready} = 5'b00011;
		n_fail = 0;
		comparisons = 0;
		repeat (2) @(posedge core_clk);
		chk(32'({channel_fault_n, channel_fault_oe, system_reset_n, system_reset_oe, irq}), 32'h7e04);
		rst_n <= 1'b1;
		axr(svrw_pkg::REG_MASK, rd, rs);
		chk(rd, 32'h0);
		axr(svrw_pkg::REG_EXT_TIMEOUT, rd, rs);
		chk(rd, svrw_pkg::EXT_TIMEOUT_RST);
		wait_lvl(1'b0, 20);
		wait_lvl(1'b1, 60);
		chk_span(n, RTK * TDIV, RTK * TDIV + 10);
		$display("test power-up done");
		foreach (rows[i])
		begin
			monitored_rail <= rows[i].rail;
			repeat (7) @(posedge core_clk);
			chk(32'(channel_fault_n), 32'(rows[i].fault_n));
			chk(32'(channel_fault_oe), {26'h0, ~rows[i].fault_n});
			chk(32'(system_reset_n), 32'(rows[i].rst_n));
		end
		wait_lvl(1'b1, 40);
		$display("test rail rows done");
		mr_hold <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk(32'({system_reset_n, system_reset_oe}), 32'h1);
		mr_hold <= 1'b0;
		wait_lvl(1'b1, 60);
		chk_span(n, RTK * TDIV + 1, RTK * TDIV + TDIV + 8);
		axw(svrw_pkg::REG_MASK, 32'h0, rs);
		axr(svrw_pkg::REG_STATUS, rd, rs);
		chk(rd & 32'h2, 32'h2);
		chk(32'(irq), 32'h0);
		axw(svrw_pkg::REG_MASK, 32'h2, rs);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h1);
		axw(svrw_pkg::REG_STATUS, 32'h2, rs);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0);
		$display("test manual reset and interrupt done");
		axw(svrw_pkg::REG_EXT_TIMEOUT, 32'd30, rs);
		timeout_select_input <= 1'b0;
		mr_hold <= 1'b1;
		repeat (20) @(posedge core_clk);
		mr_hold <= 1'b0;
		wait_lvl(1'b1, 200);
		chk_span(n, 30 * TDIV + 1, 30 * TDIV + TDIV + 8);
		timeout_select_input <= 1'b1;
		$display("test external timeout done");
		margin_n <= 1'b0;
		monitored_rail <= 6'h00;
		repeat (8) @(posedge core_clk);
		chk(32'({channel_fault_n, channel_fault_oe, system_reset_n, system_reset_oe}), 32'h3f02);
		margin_n <= 1'b1;
		repeat (7) @(posedge core_clk);
		chk(32'(system_reset_n), 32'h0);
		monitored_rail <= 6'h3f;
		wait_lvl(1'b1, 60);
		$display("test margin done");
		n = 0;
		repeat (200)
		begin
			@(posedge core_clk);
			if (system_reset_n !== 1'b1)
				n++;
		end
		chk_span(n, 0, 0);
		kick_en <= 1'b0;
		wait_lvl(1'b0, 100);
		chk_span(n, WTK * TDIV - 12, WTK * TDIV + TDIV + 6);
		wait_lvl(1'b1, 60);
		axr(svrw_pkg::REG_STATUS, rd, rs);
		chk(rd & 32'h4, 32'h4);
		wait_lvl(1'b0, 200);
		chk_span(n, STK * TDIV - TDIV - 8, STK * TDIV + TDIV + 4);
		$display("test watchdog expiry done");
		wait_lvl(1'b1, 60);
		float_en <= 1'b1;
		n = 0;
		repeat (300)
		begin
			@(posedge core_clk);
			if (system_reset_n !== 1'b1)
				n++;
		end
		chk_span(n, 0, 0);
		axr(svrw_pkg::REG_LIVE, rd, rs);
		chk(rd & 32'h80, 32'h0);
		$display("test floating kick line done");
		axr(8'h10, rd, rs);
		chk({rd[29:0], rs}, {30'h0, svrw_pkg::RESP_SLVERR});
		axw(8'h14, 32'h5, rs);
		chk(32'(rs), 32'(svrw_pkg::RESP_SLVERR));
		$display("test unmapped access done");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
